// >>> rtl/line_status_pkg.sv
// constants for the line status and interrupt flag block
package line_status_pkg;

   // register offsets on the control interface
   localparam logic [7:0] LINE_STATUS_0_OFS      = 8'h17;
   localparam logic [7:0] LINE_STATUS_1_OFS      = 8'h18;
   localparam logic [7:0] INTERRUPT_STATUS_0_OFS = 8'h19;
   localparam logic [7:0] INTERRUPT_STATUS_1_OFS = 8'h1a;

   // line_status_0 bit positions
   localparam int EQ_RANGE_BIT      = 7;
   localparam int LB_ACTIVATE_BIT   = 6;
   localparam int LB_DEACTIVATE_BIT = 5;
   localparam int PATTERN_SYNC_BIT  = 4;
   localparam int TX_CLOCK_LOSS_BIT = 3;
   localparam int DRIVER_FAIL_BIT   = 2;
   localparam int ALARM_IND_BIT     = 1;
   localparam int SIGNAL_LOSS_BIT   = 0;

   // line_status_1 field layout
   localparam int REMOTE_LOOP_BIT  = 5;
   localparam int ATTEN_LSB        = 0;
   localparam int ATTEN_WIDTH      = 5;
   localparam logic [1:0] LINE_STATUS_1_RSVD = 2'h0;

   // interrupt_status_1 bit positions
   localparam int AMP_OVERFLOW_BIT  = 7;
   localparam int JA_OVERFLOW_BIT   = 6;
   localparam int JA_UNDERFLOW_BIT  = 5;
   localparam int PATTERN_ERROR_BIT = 4;
   localparam int EXCESS_ZEROS_BIT  = 3;
   localparam int CODE_VIOL_BIT     = 2;
   localparam int SECOND_TIMER_BIT  = 1;
   localparam int CNT_OVERFLOW_BIT  = 0;

   // reset values and the data read from unmapped offsets
   localparam logic [7:0] FLAGS_RESET   = 8'h00;
   localparam logic [7:0] RD_DATA_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;

   // transmit clock loss: idle master clock cycles tolerated
   localparam int TX_CLOCK_LOSS_CYCLES = 70;

endpackage

// >>> rtl/flag_event_if.sv
// carrier between a live status flag and its event detector
`timescale 1ns/10ps
interface flag_event_if;
   logic live;
   logic mask;
   logic edgeSel;
   logic event_;

   modport detector (
      input  live,
      input  mask,
      input  edgeSel,
      output event_
   );

   modport source (
      output live,
      output mask,
      output edgeSel,
      input  event_
   );
endinterface

// >>> rtl/live_flag_event.sv
// turns one live status flag into a one-cycle interrupt event pulse
`timescale 1ns/10ps
module live_flag_event (
   input  wire logic        ref_clk, // master clock
   input  wire logic        srst,    // synchronous reset, high
   flag_event_if.detector   flag     // live flag in, event out
);

   typedef struct packed {
      logic prev;
      logic event_;
   } state_s;

   state_s state_q;
   state_s state_d;

   always_comb begin
      state_d      = state_q;
      state_d.prev = flag.live;
      // masked flag never raises an event; edge select picks rise only or any change
      state_d.event_ = !flag.mask &&
                       (flag.edgeSel ? (flag.live != state_q.prev)
                                     : (flag.live && !state_q.prev));
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign flag.event_ = state_q.event_;

endmodule

// >>> rtl/line_status_interrupt_flags.sv
// line status registers and clear-on-read interrupt flags of the line interface
//
// Contract
// - status0 bit1 shows live alarm indication
// - alarm interrupt on rise or any change
// - status0 bit0 shows live signal loss
// - loss interrupt on rise or any change
// - status1 bit5 remote loopback, bits7-6 zero
// - status1 bits4-0 carry attenuation code
// - reading interrupt status 0 clears it
// - reading interrupt status 1 clears it
// - int0 bit7 latches equalizer range event
// - int0 bit6 latches loopback activate event
// - int0 bit5 latches loopback deactivate event
// - int0 bit4 latches pattern sync event
// - int0 bit3 latches transmit clock loss
// - int0 bit2 latches driver failure event
// - int0 bits1,0 latch alarm, loss events
// - int1 bit7 latches amplitude overflow
// - int1 bits6,5 latch jitter over/underflow
// - int1 bit4 latches pattern error
// - int1 bit3 latches excess zeros
// - int1 bit2 latches code violation
// - int1 bit1 latches second timer expiry
// - int1 bit0 latches counter overflow
// - clock loss after 70 idle cycles
`timescale 1ns/10ps
module line_status_interrupt_flags #(
   parameter int TxLossCycles = line_status_pkg::TX_CLOCK_LOSS_CYCLES
) (
   input  wire logic       ref_clk,                       // master clock, 200 MHz
   input  wire logic       srst,                          // synchronous reset, high
   // control interface read port
   input  wire logic [7:0] regAddr,                       // register offset
   input  wire logic       regRd,                         // one-cycle read strobe
   output logic [7:0]      regRdData_q,                   // read data, next cycle
   output logic            regRdValid_q,                  // read data valid pulse
   // live line conditions from the detectors
   input  wire logic       alarm_indication_live,         // alarm in receive path
   input  wire logic       signal_loss_live,              // loss on receive pair
   input  wire logic       equalizer_out_of_range,        // equalizer status
   input  wire logic       loopback_activate_live,        // activate code status
   input  wire logic       loopback_deactivate_live,      // deactivate code status
   input  wire logic       pattern_sync_live,             // pattern checker in sync
   input  wire logic       driver_failure_live,           // line driver short
   input  wire logic       transmit_clock_in,             // transmit clock pin
   input  wire logic       remote_loopback_active,        // remote loopback on
   input  wire logic [4:0] attenuation_code,              // cable loss band
   // per-flag masks and edge selects, bit order as line_status_0
   input  wire logic [7:0] statusMask,                    // 1 masks the event
   input  wire logic [7:0] statusEdgeSel,                 // 1 = any change
   // event pulses for interrupt_status_1
   input  wire logic       amplitude_overflow_event,      // waveform overflow
   input  wire logic       jitter_buffer_overflow_event,  // jitter buffer over
   input  wire logic       jitter_buffer_underflow_event, // jitter buffer under
   input  wire logic       pattern_error_event,           // pattern logic error
   input  wire logic       excess_zeros_event,            // excessive zeros
   input  wire logic       code_violation_event,          // code violation
   input  wire logic       second_timer_event,            // one-second tick
   input  wire logic       counter_overflow_event,        // error counter wrap
   // outputs
   output logic            transmit_clock_loss_live_q,    // live clock loss flag
   output logic            irq_q                          // interrupt request, high
);

   localparam int CntWidth = $clog2(TxLossCycles + 2);

   // counter width follows the limit; refuse limits outside 1 to 4095
   if (TxLossCycles < 1 || TxLossCycles > 4095) begin : g_bad_loss
      $error("TxLossCycles out of range");
   end

   typedef logic [CntWidth-1:0] count_t;

   localparam count_t LossLimit = count_t'(TxLossCycles);

   typedef struct packed {
      logic [7:0] intFlags0;
      logic [7:0] intFlags1;
      logic [7:0] rdData;
      logic       rdValid;
      logic       irq;
      logic       txClkPrev;
      count_t     txIdleCount;
      logic       txClkLoss;
   } state_s;

   state_s state_q;
   state_s state_d;

   // one event detector per line_status_0 bit
   logic [7:0] liveVec;
   logic [7:0] statusEvent;

   always_comb begin
      liveVec                                      = '0;
      liveVec[line_status_pkg::EQ_RANGE_BIT]       = equalizer_out_of_range;
      liveVec[line_status_pkg::LB_ACTIVATE_BIT]    = loopback_activate_live;
      liveVec[line_status_pkg::LB_DEACTIVATE_BIT]  = loopback_deactivate_live;
      liveVec[line_status_pkg::PATTERN_SYNC_BIT]   = pattern_sync_live;
      liveVec[line_status_pkg::TX_CLOCK_LOSS_BIT]  = state_q.txClkLoss;
      liveVec[line_status_pkg::DRIVER_FAIL_BIT]    = driver_failure_live;
      liveVec[line_status_pkg::ALARM_IND_BIT]      = alarm_indication_live;
      liveVec[line_status_pkg::SIGNAL_LOSS_BIT]    = signal_loss_live;
   end

   flag_event_if flagIf [8] ();

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_flag
         assign flagIf[gi].live    = liveVec[gi];
         assign flagIf[gi].mask    = statusMask[gi];
         assign flagIf[gi].edgeSel = statusEdgeSel[gi];
         assign statusEvent[gi]    = flagIf[gi].event_;

         live_flag_event u_event (
            .ref_clk (ref_clk),
            .srst    (srst),
            .flag    (flagIf[gi])
         );
      end
   endgenerate

   // address decode for clear-on-read of both interrupt status registers
   function automatic logic isReadOf(input logic       rd,
                                     input logic [7:0] addr,
                                     input logic [7:0] ofs);
      isReadOf = rd && (addr == ofs);
   endfunction

   logic [7:0] lineStatus0;
   logic [7:0] lineStatus1;
   logic [7:0] events1;
   logic       rdInt0;
   logic       rdInt1;

   always_comb begin
      lineStatus0 = liveVec;
      lineStatus1 = {line_status_pkg::LINE_STATUS_1_RSVD,
                     remote_loopback_active,
                     attenuation_code};

      events1                                      = '0;
      events1[line_status_pkg::AMP_OVERFLOW_BIT]   = amplitude_overflow_event;
      events1[line_status_pkg::JA_OVERFLOW_BIT]    = jitter_buffer_overflow_event;
      events1[line_status_pkg::JA_UNDERFLOW_BIT]   = jitter_buffer_underflow_event;
      events1[line_status_pkg::PATTERN_ERROR_BIT]  = pattern_error_event;
      events1[line_status_pkg::EXCESS_ZEROS_BIT]   = excess_zeros_event;
      events1[line_status_pkg::CODE_VIOL_BIT]      = code_violation_event;
      events1[line_status_pkg::SECOND_TIMER_BIT]   = second_timer_event;
      events1[line_status_pkg::CNT_OVERFLOW_BIT]   = counter_overflow_event;

      rdInt0 = isReadOf(regRd, regAddr, line_status_pkg::INTERRUPT_STATUS_0_OFS);
      rdInt1 = isReadOf(regRd, regAddr, line_status_pkg::INTERRUPT_STATUS_1_OFS);
   end

   always_comb begin
      state_d = state_q;

      // idle counter saturates one past the limit
      state_d.txClkPrev = transmit_clock_in;
      if (transmit_clock_in != state_q.txClkPrev) begin
         state_d.txIdleCount = '0;
      end else if (state_q.txIdleCount <= LossLimit) begin
         state_d.txIdleCount = state_q.txIdleCount + count_t'(1);
      end
      // more than the limit without a toggle
      state_d.txClkLoss = (state_d.txIdleCount > LossLimit);

      state_d.intFlags0 = (rdInt0 ? 8'h00 : state_q.intFlags0) | statusEvent;
      state_d.intFlags1 = (rdInt1 ? 8'h00 : state_q.intFlags1) | events1;

      state_d.irq = |{state_d.intFlags0, state_d.intFlags1};

      // read data returns pre-clear flags; unmapped offsets read zero
      state_d.rdValid = regRd;
      state_d.rdData  = state_q.rdData;
      if (regRd) begin
         case (regAddr)
            line_status_pkg::LINE_STATUS_0_OFS: begin
               state_d.rdData = lineStatus0;
            end
            line_status_pkg::LINE_STATUS_1_OFS: begin
               state_d.rdData = lineStatus1;
            end
            line_status_pkg::INTERRUPT_STATUS_0_OFS: begin
               state_d.rdData = state_q.intFlags0;
            end
            line_status_pkg::INTERRUPT_STATUS_1_OFS: begin
               state_d.rdData = state_q.intFlags1;
            end
            default: begin
               state_d.rdData = line_status_pkg::UNMAPPED_DATA;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_q.intFlags0   <= line_status_pkg::FLAGS_RESET;
         state_q.intFlags1   <= line_status_pkg::FLAGS_RESET;
         state_q.rdData      <= line_status_pkg::RD_DATA_RESET;
         state_q.rdValid     <= 1'b0;
         state_q.irq         <= 1'b0;
         state_q.txClkPrev   <= 1'b0;
         state_q.txIdleCount <= '0;
         state_q.txClkLoss   <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   assign regRdData_q                = state_q.rdData;
   assign regRdValid_q               = state_q.rdValid;
   assign irq_q                      = state_q.irq;
   assign transmit_clock_loss_live_q = state_q.txClkLoss;

endmodule

// >>> testbench/line_status_interrupt_flags_monitor.sv
// concurrent checks on the line status and interrupt flag ports
`timescale 1ns/10ps
module line_status_interrupt_flags_monitor #(
   parameter int TxLossCycles = 70
) (
   input wire logic       ref_clk,                    // clock
   input wire logic       srst,                       // reset
   input wire logic [7:0] regAddr,                    // offset
   input wire logic       regRd,                      // strobe
   input wire logic [7:0] regRdData_q,                // data
   input wire logic       regRdValid_q,               // valid
   input wire logic       alarm_indication_live,      // alarm
   input wire logic       signal_loss_live,           // loss
   input wire logic       transmit_clock_in,          // tx clock
   input wire logic       remote_loopback_active,     // loopback
   input wire logic [4:0] attenuation_code,           // cable loss
   input wire logic [7:0] statusMask,                 // masks
   input wire logic       code_violation_event,       // event
   input wire logic       counter_overflow_event,     // event
   input wire logic       transmit_clock_loss_live_q, // clock loss
   input wire logic       irq_q                       // request
);
   logic txPrev_q;
   int   idleCnt_q;
   // saturates so a long stall cannot wrap
   always_ff @(posedge ref_clk) begin
      txPrev_q <= transmit_clock_in;
      if (srst || transmit_clock_in != txPrev_q) idleCnt_q <= 0;
      else if (idleCnt_q < 4000) idleCnt_q <= idleCnt_q + 1;
   end
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (srst);
   sequence rdAt(logic [7:0] ofs);
      regRd && regAddr == ofs;
   endsequence
   sequence quiet;
      !code_violation_event && !counter_overflow_event;
   endsequence
   AST_RD_VALID:
      assert property (regRd |=> regRdValid_q) else $error("read not answered");
   AST_VALID_PULSE:
      assert property (!regRd |=> !regRdValid_q) else $error("valid without read");
   AST_LINE_STATUS_0_LIVE:
      assert property (rdAt(8'h17) |=> regRdData_q[1:0] ==
         $past({alarm_indication_live, signal_loss_live})) else $error("status0 live bits");
   AST_LINE_STATUS_1_LIVE:
      assert property (rdAt(8'h18) |=> regRdData_q ==
         {2'b00, $past(remote_loopback_active), $past(attenuation_code)})
         else $error("status1 fields");
   AST_LOSS_SET:
      assert property (idleCnt_q > TxLossCycles + 2 |-> transmit_clock_loss_live_q)
         else $error("clock loss not flagged");
   AST_LOSS_QUIET:
      assert property (idleCnt_q >= 3 && idleCnt_q < TxLossCycles - 1
         |-> !transmit_clock_loss_live_q) else $error("clock loss too early");
   AST_EVT_IRQ:
      assert property (counter_overflow_event |=> irq_q) else $error("event without request");
   AST_EVT_LATCH:
      assert property (code_violation_event ##1 !regRd [*2] ##1 rdAt(8'h1a)
         |=> regRdData_q[2]) else $error("code violation not latched");
   AST_CLEAR1:
      assert property (quiet ##1 rdAt(8'h1a) ##0 quiet ##1 rdAt(8'h1a)
         |=> regRdData_q[2] == 1'b0 && regRdData_q[0] == 1'b0) else $error("flags not cleared");
   AST_ALARM_IRQ:
      assert property ($rose(alarm_indication_live) && !statusMask[1] |-> ##[1:3] irq_q)
         else $error("alarm rise without request");
endmodule

bind line_status_interrupt_flags line_status_interrupt_flags_monitor
   #(.TxLossCycles(TxLossCycles)) i_mon (.*);

// >>> testbench/host_reader.sv
// host side model issuing register reads
`timescale 1ns/10ps
module host_reader (
   input  wire logic  ref_clk, // clock
   output logic       regRd,   // read strobe
   output logic [7:0] regAddr  // offset
);
   initial begin
      regRd = 1'b0;
      regAddr = 8'h00;
   end
   // strobe stays up so reads can run back to back
   task automatic rd(input logic [7:0] a);
      @(negedge ref_clk);
      regRd <= 1'b1;
      regAddr <= a;
   endtask
   // released address inverted, never left at the last value
   task automatic idle();
      @(negedge ref_clk);
      regRd <= 1'b0;
      regAddr <= ~regAddr;
   endtask
endmodule

// >>> testbench/testbench.sv
// self-checking bench for the line status and interrupt flag block
`timescale 1ns/10ps
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin fails++; \
   $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module testbench;
   localparam int LossCyc = 5;
   logic       ref_clk = 1'b0, srst = 1'b1, txClk = 1'b0, txRun = 1'b1, rlb = 1'b0;
   logic       regRd, regRdValid_q, loss, irq_q;
   logic [7:0] regAddr, regRdData_q, exp0, live0 = 8'h00, mask = 8'h00;
   logic [7:0] esel = 8'h00, ev1 = 8'h00, burst;
   logic [4:0] att = 5'h00;
   logic [4:0] bnd[4] = '{5'h00, 5'h15, 5'h16, 5'h1f};
   logic [7:0] expq[$];
   int         fails = 0, checked = 0, seed;

   host_reader h (.ref_clk(ref_clk), .regRd(regRd), .regAddr(regAddr));
   line_status_interrupt_flags #(.TxLossCycles(LossCyc)) i_dut (
      .ref_clk(ref_clk), .srst(srst), .regAddr(regAddr), .regRd(regRd),
      .regRdData_q(regRdData_q), .regRdValid_q(regRdValid_q),
      .alarm_indication_live(live0[1]), .signal_loss_live(live0[0]),
      .equalizer_out_of_range(live0[7]), .loopback_activate_live(live0[6]),
      .loopback_deactivate_live(live0[5]), .pattern_sync_live(live0[4]),
      .driver_failure_live(live0[2]), .transmit_clock_in(txClk),
      .remote_loopback_active(rlb), .attenuation_code(att),
      .statusMask(mask), .statusEdgeSel(esel),
      .amplitude_overflow_event(ev1[7]), .jitter_buffer_overflow_event(ev1[6]),
      .jitter_buffer_underflow_event(ev1[5]), .pattern_error_event(ev1[4]),
      .excess_zeros_event(ev1[3]), .code_violation_event(ev1[2]),
      .second_timer_event(ev1[1]), .counter_overflow_event(ev1[0]),
      .transmit_clock_loss_live_q(loss), .irq_q(irq_q));

   always #2.5 ref_clk = ~ref_clk;
   always @(negedge ref_clk) if (txRun) txClk <= ~txClk;
   // answers are matched oldest first
   always @(negedge ref_clk) begin
      if (regRdValid_q === 1'b1) begin
         exp0 = (expq.size() > 0) ? expq.pop_front() : 8'hxx;
         `CHK("read data", exp0, regRdData_q)
      end
   end

   task automatic wrap_up();
      $display("checked %0d, fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic r(input logic [7:0] a, input logic [7:0] e);
      expq.push_back(e);
      h.rd(a);
      h.idle();
   endtask
   task automatic drain(input string nm);
      for (int i = 0; i < 20 && expq.size() > 0; i++) cyc(1);
      if (expq.size() > 0) begin
         fails++;
         wrap_up();
      end else begin
         $display("%s done", nm);
      end
   endtask
   task automatic step(input int i, input logic lv, input logic hit);
      live0[i] = lv;
      cyc(3);
      r(8'h17, 8'({7'h00, lv} << i));
      r(8'h19, 8'({7'h00, hit} << i));
   endtask

   initial begin
      seed = $urandom(32'he30d8c33);
      cyc(2);
      srst = 1'b0;
      for (int a = 8'h17; a <= 8'h1b; a++) r(8'(a), 8'h00);
      drain("reset");
      for (int i = 0; i < 12; i++) begin
         att = (i < 4) ? bnd[i] : 5'($urandom);
         rlb = 1'($urandom);
         r(8'h18, {2'b00, rlb, att});
      end
      drain("line status 1");
      for (int i = 0; i < 8; i++) begin
         ev1[i] = 1'b1;
         cyc(1);
         ev1[i] = 1'b0;
         cyc(1);
         `CHK("irq set", 1'b1, irq_q)
         r(8'h1a, 8'(8'h01 << i));
         r(8'h1a, 8'h00);
         `CHK("irq clear", 1'b0, irq_q)
      end
      // event in the same cycle as the clearing read
      expq.push_back(8'h00);
      h.rd(8'h1a);
      ev1[2] = 1'b1;
      h.idle();
      ev1[2] = 1'b0;
      expq.push_back(8'h04);
      expq.push_back(8'h00);
      h.rd(8'h1a);
      h.rd(8'h1a);
      h.idle();
      // random burst of several sources in one cycle
      ev1 = 8'($urandom);
      burst = ev1;
      cyc(1);
      ev1 = 8'h00;
      `CHK("irq burst", |burst, irq_q)
      r(8'h1a, burst);
      drain("interrupt status 1");
      for (int i = 0; i < 8; i++) begin
         if (i != 3) begin
            step(i, 1'b1, 1'b1);
            step(i, 1'b0, 1'b0);
            esel[i] = 1'b1;
            step(i, 1'b1, 1'b1);
            step(i, 1'b0, 1'b1);
            mask[i] = 1'b1;
            step(i, 1'b1, 1'b0);
            step(i, 1'b0, 1'b0);
            mask[i] = 1'b0;
            esel[i] = 1'b0;
         end
      end
      drain("interrupt status 0");
      // random levels under random masks and edge selects, rising from all clear
      mask  = 8'($urandom);
      esel  = 8'($urandom);
      live0 = 8'($urandom) & 8'hf7;
      cyc(3);
      r(8'h17, live0);
      r(8'h19, live0 & ~mask);
      // masked return to idle leaves no falling-edge events behind
      mask  = 8'hff;
      live0 = 8'h00;
      cyc(3);
      mask  = 8'h00;
      esel  = 8'h00;
      r(8'h19, 8'h00);
      drain("random status 0");
      txRun = 1'b0;
      cyc(LossCyc + 6);
      `CHK("clock loss", 1'b1, loss)
      r(8'h17, 8'h08);
      r(8'h19, 8'h08);
      txRun = 1'b1;
      cyc(4);
      `CHK("clock loss", 1'b0, loss)
      r(8'h19, 8'h00);
      `CHK("irq clear", 1'b0, irq_q)
      drain("clock loss");
      wrap_up();
   end
endmodule
